// file: common/mas_alu_if.sv
`timescale 1ns/1ps
// ==========================================================
// Operands and results between sequencer and arithmetic unit
interface mas_alu_if;
   import mas_pkg::*;
   mas_op_t           op;        // Operation
   logic [DATA_W-1:0] acc;       // Accumulator in
   logic [DATA_W-1:0] mem;       // Addressed byte in
   logic [3:0]        flags_in;  // C, AC, Z, OV in
   logic [DATA_W-1:0] result;    // Result byte
   logic [3:0]        flags_out; // C, AC, Z, OV out
   logic              wr_acc;    // Result goes to accumulator
   logic              wr_mem;    // Result goes to memory

   modport core (output op, acc, mem, flags_in, input result, flags_out, wr_acc, wr_mem);
   modport alu  (input op, acc, mem, flags_in, output result, flags_out, wr_acc, wr_mem);
endinterface : mas_alu_if

// file: common/mas_pkg.sv
// ==========================================================
// Shared constants and types of the execution subset
package mas_pkg;

   // Data path and bus widths
   localparam int DATA_W = 8;
   localparam int MEM_AW = 7;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam int PC_WIDTH = 11;
   localparam int MEM_WORDS = 120;

   // Register byte offsets
   localparam logic [APB_AW-1:0] OFS_CMD    = 8'h00;
   localparam logic [APB_AW-1:0] OFS_ACC    = 8'h04;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;
   localparam logic [APB_AW-1:0] OFS_PC     = 8'h0c;
   localparam logic [APB_AW-1:0] OFS_MADDR  = 8'h10;
   localparam logic [APB_AW-1:0] OFS_MDATA  = 8'h14;

   // Command register field positions
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_JUMP_LSB = 16;

   // Status register bit positions
   localparam int FL_C    = 0;
   localparam int FL_AC   = 1;
   localparam int FL_Z    = 2;
   localparam int FL_OV   = 3;
   localparam int FL_PDF  = 4;
   localparam int FL_TO   = 5;
   localparam int FL_BUSY = 6;
   localparam int FL_W    = 6;

   // Values after reset
   localparam logic [DATA_W-1:0] RST_ACC    = 8'h00;
   localparam logic [FL_W-1:0]   RST_FLAGS  = 6'h00;
   localparam logic [MEM_AW-1:0] RST_MADDR  = 7'h00;

   // Decimal adjust figures
   localparam logic [4:0] BCD_MAX = 5'h09;
   localparam logic [4:0] BCD_FIX = 5'h06;

   // Operation codes held in the command register
   typedef enum logic [2:0] {
      OP_CPL_ACC = 3'h0,
      OP_DEC_ACC = 3'h1,
      OP_DEC_MEM = 3'h2,
      OP_INC_MEM = 3'h3,
      OP_INC_ACC = 3'h4,
      OP_DEC_ADJ = 3'h5,
      OP_HALT    = 3'h6,
      OP_JUMP    = 3'h7
   } mas_op_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } mas_state_t;

endpackage : mas_pkg

// file: logic/mas_alu.sv
`timescale 1ns/1ps
// ==========================================================
// Result and flag computation for one operation
module mas_alu (
   mas_alu_if.alu bus // Operands and results
);
   import mas_pkg::*;

   // Nibble correction: {hit, 5-bit sum}
   function automatic logic [5:0] bcd_fix(input logic [4:0] v, input logic force_fix);
      logic hit;
      hit = (v > BCD_MAX) || force_fix;
      return {hit, hit ? v + BCD_FIX : v};
   endfunction : bcd_fix

   logic [5:0] lo_fix;
   logic [5:0] hi_fix;
   logic [4:0] hi_sum;

   // Operation decode and result
   always_comb begin
      lo_fix         = bcd_fix({1'b0, bus.acc[3:0]}, bus.flags_in[FL_AC]);
      hi_sum         = {1'b0, bus.acc[7:4]} + {4'h0, lo_fix[4]};
      hi_fix         = bcd_fix(hi_sum, bus.flags_in[FL_C]);
      bus.result     = bus.acc;
      bus.flags_out  = bus.flags_in;
      bus.wr_acc     = 1'b0;
      bus.wr_mem     = 1'b0;
      case (bus.op)
         OP_CPL_ACC: begin
            bus.result = ~bus.mem;
            bus.wr_acc = 1'b1;
         end
         OP_DEC_ACC: begin
            bus.result = bus.mem - 8'h01;
            bus.wr_acc = 1'b1;
         end
         OP_DEC_MEM: begin
            bus.result = bus.mem - 8'h01;
            bus.wr_mem = 1'b1;
         end
         OP_INC_MEM: begin
            bus.result = bus.mem + 8'h01;
            bus.wr_mem = 1'b1;
         end
         OP_INC_ACC: begin
            bus.result = bus.mem + 8'h01;
            bus.wr_acc = 1'b1;
         end
         OP_DEC_ADJ: begin
            bus.result = {hi_fix[3:0], lo_fix[3:0]};
            bus.wr_mem = 1'b1;
         end
         default: begin
         end
      endcase
      // Zero flag for every byte-producing operation except decimal adjust
      if (bus.wr_acc || (bus.wr_mem && bus.op != OP_DEC_ADJ)) begin
         bus.flags_out[FL_Z] = (bus.result == 8'h00);
      end
      // Only carry moves for decimal adjust
      if (bus.op == OP_DEC_ADJ && hi_fix[5]) begin
         bus.flags_out[FL_C] = 1'b1;
      end
   end

endmodule : mas_alu

// file: logic/mas_data_mem.sv
`timescale 1ns/1ps
// ==========================================================
// Byte data memory, one write port and two read ports
module mas_data_mem #(
   parameter int DEPTH = mas_pkg::MEM_WORDS // Bytes held
) (
   input  wire logic                       i_clk,     // System clock
   input  wire logic                       i_wr_en,   // Write strobe
   input  wire logic [mas_pkg::MEM_AW-1:0] i_wr_addr, // Write address
   input  wire logic [mas_pkg::DATA_W-1:0] i_wr_data, // Write byte
   input  wire logic [mas_pkg::MEM_AW-1:0] i_ra_addr, // Read address A
   output logic      [mas_pkg::DATA_W-1:0] o_ra_data, // Read byte A
   input  wire logic [mas_pkg::MEM_AW-1:0] i_rb_addr, // Read address B
   output logic      [mas_pkg::DATA_W-1:0] o_rb_data  // Read byte B
);
   import mas_pkg::*;

   logic [DATA_W-1:0] mem_arr [DEPTH];

   // Write port, addresses past the end are dropped
   always_ff @(posedge i_clk) begin
      if (i_wr_en && (int'(i_wr_addr) < DEPTH)) begin
         mem_arr[i_wr_addr] <= i_wr_data;
      end
   end

   // Read ports, unbacked addresses read zero
   always_comb begin
      o_ra_data = (int'(i_ra_addr) < DEPTH) ? mem_arr[i_ra_addr] : 8'h00;
      o_rb_data = (int'(i_rb_addr) < DEPTH) ? mem_arr[i_rb_addr] : 8'h00;
   end

endmodule : mas_data_mem

// file: logic/mas_exec_top.sv
`timescale 1ns/1ps
// ==========================================================
// Execution unit for an instruction subset, APB register access

module mas_exec_top #(
   parameter int PC_W      = mas_pkg::PC_WIDTH, // Program counter width
   parameter int MEM_DEPTH = mas_pkg::MEM_WORDS // Data memory bytes
) (
   input  wire logic                       i_clk,      // 200 MHz clock
   input  wire logic                       i_reset,    // Sync reset, high
   input  wire logic                       i_psel,     // APB select
   input  wire logic                       i_penable,  // APB enable
   input  wire logic                       i_pwrite,   // APB write
   input  wire logic [mas_pkg::APB_AW-1:0] i_paddr,    // APB address
   input  wire logic [mas_pkg::APB_DW-1:0] i_pwdata,   // APB write data
   output logic      [mas_pkg::APB_DW-1:0] o_prdata,   // APB read data
   output logic                            o_pready,   // APB ready
   output logic                            o_pslverr,  // APB error
   input  wire logic                       i_wake,     // Wake-up pin
   output logic                            o_osc_stop, // Oscillator stopped
   output logic                            o_power_down_flag,    // Power-down flag
   output logic                            o_watchdog_expiry_flag // Expiry flag
);
   import mas_pkg::*;

   // =======================================================
   // State
   mas_state_t        state_reg, state_next;
   mas_op_t           op_reg, op_next;
   logic [MEM_AW-1:0] opaddr_reg, opaddr_next;
   logic [PC_W-1:0]   jaddr_reg, jaddr_next;
   logic [DATA_W-1:0] acc_reg, acc_next;
   logic [FL_W-1:0]   flags_reg, flags_next;
   logic [PC_W-1:0]   pc_reg, pc_next;
   logic [MEM_AW-1:0] maddr_reg, maddr_next;
   logic              osc_stop_reg, osc_stop_next;
   logic [2:0]        wake_sync_reg, wake_sync_next;
   logic              pready_reg, pready_next;
   logic              pslverr_reg, pslverr_next;
   logic [APB_DW-1:0] prdata_reg, prdata_next;

   logic              busy;
   logic              access;
   logic              wr_fire;
   logic              mapped;
   logic              mem_we;
   logic [MEM_AW-1:0] mem_waddr;
   logic [DATA_W-1:0] mem_wdata;
   logic [DATA_W-1:0] mem_op_q;
   logic [DATA_W-1:0] mem_bus_q;

   mas_alu_if alu_bus ();

   // =======================================================
   // Sub-blocks
   mas_alu u_alu (
      .bus (alu_bus.alu)
   );

   mas_data_mem #(
      .DEPTH (MEM_DEPTH)
   ) u_mem (
      .i_clk     (i_clk),
      .i_wr_en   (mem_we),
      .i_wr_addr (mem_waddr),
      .i_wr_data (mem_wdata),
      .i_ra_addr (opaddr_reg),
      .o_ra_data (mem_op_q),
      .i_rb_addr (maddr_reg),
      .o_rb_data (mem_bus_q)
   );

   // Operands to the arithmetic unit
   always_comb begin
      alu_bus.op       = op_reg;
      alu_bus.acc      = acc_reg;
      alu_bus.mem      = mem_op_q;
      alu_bus.flags_in = flags_reg[3:0];
   end

   // =======================================================
   // APB handshake
   always_comb begin
      busy    = (state_reg == ST_EXEC);
      access  = i_psel && i_penable && !pready_reg;
      wr_fire = i_psel && i_penable && pready_reg && i_pwrite && !pslverr_reg;
      mapped  = (i_paddr == OFS_CMD) || (i_paddr == OFS_ACC) || (i_paddr == OFS_STATUS)
             || (i_paddr == OFS_PC) || (i_paddr == OFS_MADDR) || (i_paddr == OFS_MDATA);
      // Writes wait while an operation runs
      pready_next  = access && !(i_pwrite && busy);
      pslverr_next = pready_next && !mapped;
      prdata_next  = prdata_reg;
      if (pready_next) begin
         if (!i_pwrite && i_paddr == OFS_CMD) begin
            prdata_next = {5'h00, jaddr_reg, 1'b0, opaddr_reg, 5'h00, op_reg};
         end else if (!i_pwrite && i_paddr == OFS_ACC) begin
            prdata_next = {24'h000000, acc_reg};
         end else if (!i_pwrite && i_paddr == OFS_STATUS) begin
            prdata_next = {25'h0000000, busy, flags_reg};
         end else if (!i_pwrite && i_paddr == OFS_PC) begin
            prdata_next = APB_DW'(pc_reg);
         end else if (!i_pwrite && i_paddr == OFS_MADDR) begin
            prdata_next = {25'h0000000, maddr_reg};
         end else if (!i_pwrite && i_paddr == OFS_MDATA) begin
            prdata_next = {24'h000000, mem_bus_q};
         end else begin
            prdata_next = 32'h00000000;
         end
      end
   end

   // =======================================================
   // Sequencer, register writes and execution
   always_comb begin
      state_next     = state_reg;
      op_next        = op_reg;
      opaddr_next    = opaddr_reg;
      jaddr_next     = jaddr_reg;
      acc_next       = acc_reg;
      flags_next     = flags_reg;
      pc_next        = pc_reg;
      maddr_next     = maddr_reg;
      osc_stop_next  = osc_stop_reg;
      wake_sync_next = {wake_sync_reg[1:0], i_wake};
      mem_we         = 1'b0;
      mem_waddr      = maddr_reg;
      mem_wdata      = i_pwdata[DATA_W-1:0];
      // Wake pin counts once the two later stages agree high
      if (osc_stop_reg && wake_sync_reg[1] && wake_sync_reg[2]) begin
         osc_stop_next = 1'b0;
      end
      case (state_reg)
         ST_IDLE: begin
            if (wr_fire && i_paddr == OFS_CMD) begin
               op_next     = mas_op_t'(i_pwdata[CMD_OP_LSB +: 3]);
               opaddr_next = i_pwdata[CMD_ADDR_LSB +: MEM_AW];
               jaddr_next  = i_pwdata[CMD_JUMP_LSB +: PC_W];
               // A stopped core takes no instruction
               if (!osc_stop_reg) begin
                  state_next = ST_EXEC;
               end
            end else if (wr_fire && i_paddr == OFS_ACC) begin
               acc_next = i_pwdata[DATA_W-1:0];
            end else if (wr_fire && i_paddr == OFS_STATUS) begin
               flags_next = i_pwdata[FL_W-1:0];
            end else if (wr_fire && i_paddr == OFS_PC) begin
               pc_next = i_pwdata[PC_W-1:0];
            end else if (wr_fire && i_paddr == OFS_MADDR) begin
               maddr_next = i_pwdata[MEM_AW-1:0];
            end else if (wr_fire && i_paddr == OFS_MDATA) begin
               mem_we = 1'b1;
            end
         end
         ST_EXEC: begin
            state_next = ST_IDLE;
            pc_next    = pc_reg + PC_W'(1);
            flags_next[3:0] = alu_bus.flags_out;
            if (alu_bus.wr_acc) begin
               acc_next = alu_bus.result;
            end
            if (alu_bus.wr_mem) begin
               mem_we    = 1'b1;
               mem_waddr = opaddr_reg;
               mem_wdata = alu_bus.result;
            end
            if (op_reg == OP_HALT) begin
               flags_next[FL_PDF] = 1'b1;
               flags_next[FL_TO]  = 1'b0;
               osc_stop_next      = 1'b1;
            end else if (op_reg == OP_JUMP) begin
               pc_next = jaddr_reg;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Register update
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg     <= ST_IDLE;
         op_reg        <= OP_CPL_ACC;
         opaddr_reg    <= RST_MADDR;
         jaddr_reg     <= '0;
         acc_reg       <= RST_ACC;
         flags_reg     <= RST_FLAGS;
         pc_reg        <= '0;
         maddr_reg     <= RST_MADDR;
         osc_stop_reg  <= 1'b0;
         wake_sync_reg <= 3'h0;
         pready_reg    <= 1'b0;
         pslverr_reg   <= 1'b0;
         prdata_reg    <= 32'h00000000;
      end else begin
         state_reg     <= state_next;
         op_reg        <= op_next;
         opaddr_reg    <= opaddr_next;
         jaddr_reg     <= jaddr_next;
         acc_reg       <= acc_next;
         flags_reg     <= flags_next;
         pc_reg        <= pc_next;
         maddr_reg     <= maddr_next;
         osc_stop_reg  <= osc_stop_next;
         wake_sync_reg <= wake_sync_next;
         pready_reg    <= pready_next;
         pslverr_reg   <= pslverr_next;
         prdata_reg    <= prdata_next;
      end
   end

   // Outputs straight from flops
   always_comb begin
      o_prdata               = prdata_reg;
      o_pready               = pready_reg;
      o_pslverr              = pslverr_reg;
      o_osc_stop             = osc_stop_reg;
      o_power_down_flag      = flags_reg[FL_PDF];
      o_watchdog_expiry_flag = flags_reg[FL_TO];
   end

   // =======================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   a_cpl_acc_value: assert property (
      (busy && op_reg == OP_CPL_ACC) |=> (acc_reg == ~$past(mem_op_q))
         && (flags_reg[FL_C] == $past(flags_reg[FL_C])) && (flags_reg[FL_Z] == (acc_reg == 8'h00)))
      else $error("complement result or flags wrong");

   a_daa_low_fix: assert property (
      (busy && op_reg == OP_DEC_ADJ && (acc_reg[3:0] > 4'h9 || flags_reg[FL_AC]))
         |-> (mem_wdata[3:0] == 4'(acc_reg[3:0] + 4'h6)) && mem_we)
      else $error("low nibble not corrected");

   a_daa_carry_set: assert property (
      (busy && op_reg == OP_DEC_ADJ && flags_reg[FL_C]) |=> flags_reg[FL_C])
      else $error("carry lost in decimal adjust");

   a_daa_only_c: assert property (
      (busy && op_reg == OP_DEC_ADJ) |=> $stable(acc_reg)
         && (flags_reg[FL_TO:FL_AC] == $past(flags_reg[FL_TO:FL_AC])))
      else $error("decimal adjust changed more than carry");

   a_decrement_to_acc_value: assert property (
      (busy && op_reg == OP_DEC_ACC) |=> (acc_reg == 8'($past(mem_op_q) - 8'h01)))
      else $error("decrement result wrong");

   a_halt_flags: assert property (
      (busy && op_reg == OP_HALT) |=> o_power_down_flag && !o_watchdog_expiry_flag
         && o_osc_stop && (pc_reg == PC_W'($past(pc_reg) + PC_W'(1))))
      else $error("halt effects missing");

   a_jump_target: assert property (
      (busy && op_reg == OP_JUMP) |=> (pc_reg == $past(jaddr_reg)) && $stable(flags_reg))
      else $error("jump target or flags wrong");

   a_inc_wrap: assert property (
      (busy && op_reg == OP_INC_MEM && mem_op_q == 8'hff)
         |-> mem_we && (mem_wdata == 8'h00) ##1 flags_reg[FL_Z])
      else $error("increment wrap or zero flag wrong");

   a_stall_busy: assert property (
      (access && i_pwrite && busy) |=> !o_pready)
      else $error("write accepted while busy");

   c_halt_wake: cover property (osc_stop_reg ##[1:100] !osc_stop_reg);
   c_daa_both: cover property (busy && op_reg == OP_DEC_ADJ && flags_reg[FL_AC] && flags_reg[FL_C]);
   c_jump: cover property (busy && op_reg == OP_JUMP);
   c_slverr: cover property (o_pready && o_pslverr);

endmodule : mas_exec_top

// file: test/mas_exec_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the execution subset over APB
module mas_exec_top_tb;
   import mas_pkg::*;

   logic              i_clk;
   logic              i_reset;
   logic              i_psel;
   logic              i_penable;
   logic              i_pwrite;
   logic [APB_AW-1:0] i_paddr;
   logic [APB_DW-1:0] i_pwdata;
   logic [APB_DW-1:0] o_prdata;
   logic              o_pready;
   logic              o_pslverr;
   logic              i_wake;
   logic              o_osc_stop;
   logic              o_power_down_flag;
   logic              o_watchdog_expiry_flag;
   int                fails;
   int                total_checks;
   logic [10:0]       exp_pc;

   // Single-byte operation table: operation, operand, result
   mas_op_t    t_op  [10] = '{OP_CPL_ACC, OP_CPL_ACC, OP_DEC_ACC, OP_DEC_ACC, OP_INC_ACC,
                              OP_INC_ACC, OP_DEC_MEM, OP_DEC_MEM, OP_INC_MEM, OP_INC_MEM};
   logic [7:0] t_in  [10] = '{8'h3c, 8'hff, 8'h01, 8'h00, 8'hff, 8'h7f, 8'h00, 8'h01, 8'hff, 8'h10};
   logic [7:0] t_res [10] = '{8'hc3, 8'h00, 8'h00, 8'hff, 8'h00, 8'h80, 8'hff, 8'h00, 8'h00, 8'h11};
   // Decimal adjust table: accumulator and incoming {half carry, carry}
   logic [7:0] d_acc [8]  = '{8'h09, 8'h0a, 8'h99, 8'h9a, 8'h00, 8'h00, 8'ha0, 8'h15};
   logic [1:0] d_fl  [8]  = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b10, 2'b01, 2'b00, 2'b10};

   mas_exec_top #(.PC_W(11), .MEM_DEPTH(120)) dut_u (
      .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_wake(i_wake), .o_osc_stop(o_osc_stop),
      .o_power_down_flag(o_power_down_flag),
      .o_watchdog_expiry_flag(o_watchdog_expiry_flag));

   // ==========================================================
   // Clock and watchdog
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // Cuts a hang short well after the tests should end
   initial begin
      repeat (20000) @(posedge i_clk);
      fails++;
      print_verdict();
   end

   // ==========================================================
   // Verdict, compare and bus tasks
   task automatic print_verdict();
      if (fails == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // Compare one value and report a mismatch
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d,
                      output logic [APB_DW-1:0] r, output logic e);
      int n;
      @(posedge i_clk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= wr;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         print_verdict();
      end
      r = o_prdata;
      e = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
      logic [APB_DW-1:0] r;
      logic              e;
      apb(1'b1, a, d, r, e);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask : wr

   task automatic rd(input logic [APB_AW-1:0] a, output logic [APB_DW-1:0] d);
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask : rd

   task automatic setmem(input logic [6:0] a, input logic [7:0] d);
      wr(OFS_MADDR, {25'h0, a});
      wr(OFS_MDATA, {24'h0, d});
   endtask : setmem

   task automatic getmem(input logic [6:0] a, output logic [APB_DW-1:0] d);
      wr(OFS_MADDR, {25'h0, a});
      rd(OFS_MDATA, d);
   endtask : getmem

   // Issue one command and poll until busy clears
   task automatic exec(input mas_op_t op, input logic [6:0] ma, input logic [10:0] ja);
      logic [APB_DW-1:0] s;
      int                n;
      wr(OFS_CMD, {5'h0, ja, 1'b0, ma, 5'h0, op});
      n = 0;
      do begin
         rd(OFS_STATUS, s);
         n++;
      end while (s[FL_BUSY] !== 1'b0 && n < 20);
      chk("busy", 32'h0, {31'h0, s[FL_BUSY]});
   endtask : exec

   // Decimal adjust expectation: {carry, byte}
   function automatic logic [8:0] daa_ref(input logic [7:0] a, input logic c, input logic ac);
      logic [4:0] lo;
      logic [4:0] hi;
      logic       cy;
      cy = c;
      lo = {1'b0, a[3:0]};
      if (lo > 5'h09 || ac) begin
         lo = lo + 5'h06;
      end
      hi = {1'b0, a[7:4]} + {4'h0, lo[4]};
      if (hi > 5'h09 || cy) begin
         hi = hi + 5'h06;
         cy = 1'b1;
      end
      return {cy, hi[3:0], lo[3:0]};
   endfunction : daa_ref

   // ==========================================================
   // Test sequence
   initial begin
      logic [APB_DW-1:0] r;
      logic [APB_DW-1:0] m;
      logic              e;
      logic              tm;
      logic              z;
      logic [6:0]        a;
      logic [8:0]        q;
      int                n;
      fails        = 0;
      total_checks = 0;
      exp_pc       = 11'h000;
      i_reset      = 1'b1;
      i_psel       = 1'b0;
      i_penable    = 1'b0;
      i_pwrite     = 1'b0;
      i_paddr      = 8'h00;
      i_pwdata     = 32'h0;
      i_wake       = 1'b0;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      // Reset values and unmapped addresses
      rd(OFS_ACC, r);
      chk("acc reset", 32'h0, r);
      rd(OFS_STATUS, r);
      chk("status reset", 32'h0, r);
      rd(OFS_PC, r);
      chk("pc reset", 32'h0, r);
      apb(1'b0, 8'h18, 32'h0, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
      apb(1'b1, 8'h1c, 32'hffffffff, r, e);
      chk("unmapped wr err", 32'h1, {31'h0, e});
      // Complement, decrement and increment with wrap
      for (int i = 0; i < 10; i++) begin
         a  = 7'(119 - i * 13);
         tm = (t_op[i] == OP_DEC_MEM) || (t_op[i] == OP_INC_MEM);
         z  = (t_res[i] == 8'h00);
         setmem(a, t_in[i]);
         wr(OFS_ACC, 32'h5a);
         wr(OFS_STATUS, 32'h0b | {29'h0, ~z, 2'b00});
         exec(t_op[i], a, 11'h000);
         exp_pc++;
         rd(OFS_ACC, r);
         chk("acc", tm ? 32'h5a : {24'h0, t_res[i]}, r);
         getmem(a, m);
         chk("mem", {24'h0, tm ? t_res[i] : t_in[i]}, m);
         rd(OFS_STATUS, r);
         chk("status", 32'h0b | {29'h0, z, 2'b00}, r);
         rd(OFS_PC, r);
         chk("pc", {21'h0, exp_pc}, r);
      end
      // Decimal adjust into memory, accumulator kept
      for (int i = 0; i < 8; i++) begin
         a = 7'(10 + i);
         q = daa_ref(d_acc[i], d_fl[i][0], d_fl[i][1]);
         setmem(a, 8'h77);
         wr(OFS_ACC, {24'h0, d_acc[i]});
         wr(OFS_STATUS, 32'h0c | {30'h0, d_fl[i]});
         exec(OP_DEC_ADJ, a, 11'h000);
         exp_pc++;
         getmem(a, m);
         chk("daa mem", {24'h0, q[7:0]}, m);
         rd(OFS_ACC, r);
         chk("daa acc", {24'h0, d_acc[i]}, r);
         rd(OFS_STATUS, r);
         chk("daa status", 32'h0c | {30'h0, d_fl[i][1], q[8]}, r);
      end
      // Direct jump, flags untouched
      wr(OFS_STATUS, 32'h2f);
      exec(OP_JUMP, 7'h00, 11'h5a5);
      rd(OFS_PC, r);
      chk("jump pc", 32'h5a5, r);
      rd(OFS_STATUS, r);
      chk("jump status", 32'h2f, r);
      exec(OP_JUMP, 7'h00, 11'h7ff);
      rd(OFS_PC, r);
      chk("jump pc max", 32'h7ff, r);
      exec(OP_JUMP, 7'h00, 11'h100);
      // Halt, command ignored while stopped, then wake
      wr(OFS_STATUS, 32'h20);
      // Flag pin is sampled one edge after the write lands
      @(posedge i_clk);
      chk("expiry pin", 32'h1, {31'h0, o_watchdog_expiry_flag});
      exec(OP_HALT, 7'h00, 11'h000);
      rd(OFS_STATUS, r);
      chk("halt status", 32'h10, r);
      rd(OFS_PC, r);
      chk("halt pc", 32'h101, r);
      rd(OFS_ACC, r);
      chk("halt acc kept", 32'h15, r);
      chk("osc stop", 32'h1, {31'h0, o_osc_stop});
      chk("pdf pin", 32'h1, {31'h0, o_power_down_flag});
      chk("expiry pin", 32'h0, {31'h0, o_watchdog_expiry_flag});
      exec(OP_JUMP, 7'h00, 11'h123);
      rd(OFS_PC, r);
      chk("pc while stopped", 32'h101, r);
      i_wake <= 1'b1;
      n = 0;
      while (o_osc_stop !== 1'b0 && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      chk("osc after wake", 32'h0, {31'h0, o_osc_stop});
      i_wake <= 1'b0;
      print_verdict();
   end

endmodule : mas_exec_top_tb
